// *** design/ultc_top.sv ***
// usb data-line termination control with an axi4-lite register slave
// Function
// - device role: pull-up on when module enable and power on are set.
// - override enable makes pull-up follow the pull-up override bit 7.
// - low bus voltage below session valid forces pull-up off.
// - host role enable bit 3 connects both data-line pull-downs.
// - override enable gives pull-downs individually to bits 5:4.
// - suspend never releases the pull-up.
// - external transceiver pins carry pull-up, pull-downs, vbus control.
`default_nettype none
module ultc_top
  import ultc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line status
  input wire logic vbus_session_valid,
  input wire logic bus_suspended,
  // on-chip termination
  output logic dplus_pullup_on,
  output logic dplus_pulldown_on,
  output logic dminus_pulldown_on,
  output logic vbus_gen_on,
  // external transceiver interface
  output logic ext_dplus_pullup,
  output logic ext_dplus_pulldown,
  output logic ext_dminus_pulldown,
  output logic ext_vbus_gen
);

  // register state
  logic [7:0] usb_control_reg, next_usb_control_reg;
  logic [7:0] otg_control_reg, next_otg_control_reg;
  logic [7:0] pwr_control_reg, next_pwr_control_reg;
  // write channel state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  // read channel state
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // line side
  logic sess_meta, sess_sync;
  logic next_pu, next_dp_pd, next_dm_pd;
  logic pu, dp_pd, dm_pd;
  logic [7:0] status_reg;
  logic do_write;
  logic wr_hit;

  // comparator is asynchronous to clock
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sess_meta <= 1'b0;
      sess_sync <= 1'b0;
    end
    else
    begin
      sess_meta <= vbus_session_valid;
      sess_sync <= sess_meta;
    end
  end

  // termination decision
  always_comb
  begin
    next_pu = 1'b0;
    next_dp_pd = 1'b0;
    next_dm_pd = 1'b0;
    if (otg_control_reg[ULTC_BIT_OTG_EN])
    begin
      next_pu = otg_control_reg[ULTC_BIT_DP_PU];
      next_dp_pd = otg_control_reg[ULTC_BIT_DP_PD];
      next_dm_pd = otg_control_reg[ULTC_BIT_DM_PD];
    end
    else
    begin
      next_pu = usb_control_reg[ULTC_BIT_USB_EN] &
                pwr_control_reg[ULTC_BIT_PWR_ON] &
                !usb_control_reg[ULTC_BIT_HOST_EN];
      next_dp_pd = usb_control_reg[ULTC_BIT_HOST_EN];
      next_dm_pd = usb_control_reg[ULTC_BIT_HOST_EN];
    end
    if (!sess_sync)
      next_pu = 1'b0;
    // suspend deliberately not a term here
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pu <= 1'b0;
      dp_pd <= 1'b0;
      dm_pd <= 1'b0;
    end
    else
    begin
      pu <= next_pu;
      dp_pd <= next_dp_pd;
      dm_pd <= next_dm_pd;
    end
  end

  // steer to on-chip or external transceiver
  assign dplus_pullup_on = pu & !pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign dplus_pulldown_on = dp_pd & !pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign dminus_pulldown_on = dm_pd & !pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign vbus_gen_on = pwr_control_reg[ULTC_BIT_VBUS_GEN] &
                       !pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign ext_dplus_pullup = pu & pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign ext_dplus_pulldown = dp_pd & pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign ext_dminus_pulldown = dm_pd & pwr_control_reg[ULTC_BIT_EXT_XCVR];
  assign ext_vbus_gen = pwr_control_reg[ULTC_BIT_VBUS_GEN] &
                        pwr_control_reg[ULTC_BIT_EXT_XCVR];

  always_comb
  begin
    status_reg = 8'h00;
    status_reg[ULTC_BIT_ST_SESS] = sess_sync;
    status_reg[ULTC_BIT_ST_PU] = pu;
    status_reg[ULTC_BIT_ST_DP_PD] = dp_pd;
    status_reg[ULTC_BIT_ST_DM_PD] = dm_pd;
    status_reg[ULTC_BIT_ST_SUSP] = bus_suspended;
    status_reg[ULTC_BIT_ST_VBUS] = pwr_control_reg[ULTC_BIT_VBUS_GEN];
  end

  // address and data may arrive in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign do_write = aw_held & w_held & !bvalid;
  assign wr_hit = (aw_addr == ULTC_OFF_USB_CTL) |
                  (aw_addr == ULTC_OFF_OTG_CTL) |
                  (aw_addr == ULTC_OFF_PWR_CTL) |
                  (aw_addr == ULTC_OFF_STATUS);

  // write path; only byte lane 0 holds bits
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_usb_control_reg = usb_control_reg;
    next_otg_control_reg = otg_control_reg;
    next_pwr_control_reg = pwr_control_reg;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? ULTC_RESP_OKAY : ULTC_RESP_SLVERR;
      if (w_strb[0])
      begin
        if (aw_addr == ULTC_OFF_USB_CTL)
          next_usb_control_reg = w_data[7:0] & ULTC_MASK_USB_CTL;
        if (aw_addr == ULTC_OFF_OTG_CTL)
          next_otg_control_reg = w_data[7:0] & ULTC_MASK_OTG_CTL;
        if (aw_addr == ULTC_OFF_PWR_CTL)
          next_pwr_control_reg = w_data[7:0] & ULTC_MASK_PWR_CTL;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ULTC_RESP_OKAY;
      usb_control_reg <= ULTC_RST_REG;
      otg_control_reg <= ULTC_RST_REG;
      pwr_control_reg <= ULTC_RST_REG;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      usb_control_reg <= next_usb_control_reg;
      otg_control_reg <= next_otg_control_reg;
      pwr_control_reg <= next_pwr_control_reg;
    end
  end

  // read path
  always_comb
  begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = ULTC_RESP_OKAY;
      next_rdata = 32'h00000000;
      if (s_axi_araddr == ULTC_OFF_USB_CTL)
        next_rdata[7:0] = usb_control_reg;
      else if (s_axi_araddr == ULTC_OFF_OTG_CTL)
        next_rdata[7:0] = otg_control_reg;
      else if (s_axi_araddr == ULTC_OFF_PWR_CTL)
        next_rdata[7:0] = pwr_control_reg;
      else if (s_axi_araddr == ULTC_OFF_STATUS)
        next_rdata[7:0] = status_reg;
      else
        next_rresp = ULTC_RESP_SLVERR;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid <= 1'b0;
      rresp <= ULTC_RESP_OKAY;
      rdata <= 32'h00000000;
    end
    else
    begin
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_pullup_vbus_low: assert property (
    !sess_sync |=> !pu)
    else $error("pull-up on while bus voltage low");
  a_pullup_device_role: assert property (
    !otg_control_reg[ULTC_BIT_OTG_EN] && sess_sync &&
    usb_control_reg[ULTC_BIT_USB_EN] && pwr_control_reg[ULTC_BIT_PWR_ON] &&
    !usb_control_reg[ULTC_BIT_HOST_EN] |=> pu)
    else $error("device role pull-up missing");
  a_pullup_override: assert property (
    otg_control_reg[ULTC_BIT_OTG_EN] && sess_sync |=>
    pu == $past(otg_control_reg[ULTC_BIT_DP_PU]))
    else $error("pull-up ignores override bit");
  a_host_pulldowns: assert property (
    !otg_control_reg[ULTC_BIT_OTG_EN] && usb_control_reg[ULTC_BIT_HOST_EN]
    |=> dp_pd && dm_pd && !pu)
    else $error("host pull-downs not both on");
  a_pulldown_override: assert property (
    otg_control_reg[ULTC_BIT_OTG_EN] |=>
    dp_pd == $past(otg_control_reg[ULTC_BIT_DP_PD]) &&
    dm_pd == $past(otg_control_reg[ULTC_BIT_DM_PD]))
    else $error("pull-downs ignore override bits");
  a_suspend_keeps_pu: assert property (
    pu && bus_suspended && $stable(usb_control_reg) &&
    $stable(otg_control_reg) && $stable(pwr_control_reg) && sess_sync
    |=> pu)
    else $error("pull-up dropped in suspend");
  a_ext_steering: assert property (
    pwr_control_reg[ULTC_BIT_EXT_XCVR] |->
    !dplus_pullup_on && !dplus_pulldown_on && !vbus_gen_on &&
    ext_dplus_pullup == pu && ext_dminus_pulldown == dm_pd &&
    !dminus_pulldown_on && ext_dplus_pulldown == dp_pd)
    else $error("external transceiver steering wrong");
  a_idle_all_off: assert property (
    usb_control_reg == 8'h00 && otg_control_reg == 8'h00 ##1
    usb_control_reg == 8'h00 && otg_control_reg == 8'h00 |->
    !pu && !dp_pd && !dm_pd)
    else $error("termination on with no request");
  a_write_answer: assert property (
    do_write |=> bvalid && !aw_held && !w_held)
    else $error("write not answered");
  a_read_hold: assert property (
    rvalid && !s_axi_rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");

  c_device_attach: cover property (!pu ##1 pu);
  c_vbus_drop: cover property (pu ##1 !sess_sync ##1 !pu);
  c_host_role: cover property (!dp_pd ##1 dp_pd && dm_pd);
  c_ext_xcvr: cover property (ext_dplus_pullup);

endmodule
`default_nettype wire

// *** design/ultc_pkg.sv ***
// constants for the usb line termination control block
`default_nettype none
package ultc_pkg;
  // register byte offsets
  localparam logic [7:0] ULTC_OFF_USB_CTL = 8'h00;
  localparam logic [7:0] ULTC_OFF_OTG_CTL = 8'h04;
  localparam logic [7:0] ULTC_OFF_PWR_CTL = 8'h08;
  localparam logic [7:0] ULTC_OFF_STATUS = 8'h0C;
  // usb_control_reg fields
  localparam int ULTC_BIT_USB_EN = 0;
  localparam int ULTC_BIT_HOST_EN = 3;
  // otg_control_reg fields
  localparam int ULTC_BIT_OTG_EN = 2;
  localparam int ULTC_BIT_DM_PD = 4;
  localparam int ULTC_BIT_DP_PD = 5;
  localparam int ULTC_BIT_DP_PU = 7;
  // power control fields
  localparam int ULTC_BIT_PWR_ON = 0;
  localparam int ULTC_BIT_VBUS_GEN = 1;
  localparam int ULTC_BIT_EXT_XCVR = 2;
  // status fields
  localparam int ULTC_BIT_ST_SESS = 0;
  localparam int ULTC_BIT_ST_PU = 1;
  localparam int ULTC_BIT_ST_DP_PD = 2;
  localparam int ULTC_BIT_ST_DM_PD = 3;
  localparam int ULTC_BIT_ST_SUSP = 4;
  localparam int ULTC_BIT_ST_VBUS = 5;
  // reset values
  localparam logic [7:0] ULTC_RST_REG = 8'h00;
  // write masks of implemented bits
  localparam logic [7:0] ULTC_MASK_USB_CTL = 8'h09;
  localparam logic [7:0] ULTC_MASK_OTG_CTL = 8'hB4;
  localparam logic [7:0] ULTC_MASK_PWR_CTL = 8'h07;
  // axi responses
  localparam logic [1:0] ULTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ULTC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** dv/ultc_far_end.sv ***
// far-side usb party: bus voltage source and suspend seen at the port
`default_nettype none
module ultc_far_end
(
  // test controls
  input wire logic host_power,
  input wire logic suspend_req,
  // from the port
  input wire logic vbus_gen_on,
  input wire logic ext_vbus_gen,
  // to the port
  output logic vbus_session_valid,
  output logic bus_suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  // own generator powers the bus in host role
  // an external generator powers the bus just as well
  assign vbus_session_valid = host_power | vbus_gen_on | ext_vbus_gen;
  // a host only suspends a powered bus
  assign bus_suspended = suspend_req & vbus_session_valid;
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the usb line termination control block
`default_nettype none
module testbench
  import ultc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] usb;
    logic [7:0] otg;
    logic [7:0] pwr;
    logic sess;
    logic susp;
    logic [7:0] exp;
  } ultc_row_t;
  ultc_row_t rows [13];
  int fails = 0;
  int compares = 0;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic host_power = 1'h0, suspend_req = 1'h0;
  logic vbus_session_valid, bus_suspended, vbus_gen_on, ext_vbus_gen;
  logic dplus_pullup_on, dplus_pulldown_on, dminus_pulldown_on;
  logic ext_dplus_pullup, ext_dplus_pulldown, ext_dminus_pulldown;
  logic [7:0] outs;
  assign outs = {dplus_pullup_on, dplus_pulldown_on, dminus_pulldown_on,
    vbus_gen_on, ext_dplus_pullup, ext_dplus_pulldown, ext_dminus_pulldown,
    ext_vbus_gen};

  always #4 clock = ~clock;

  ultc_top u_ultc_top (.clock, .rstn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .vbus_session_valid, .bus_suspended, .dplus_pullup_on,
    .dplus_pulldown_on, .dminus_pulldown_on, .vbus_gen_on,
    .ext_dplus_pullup, .ext_dplus_pulldown, .ext_dminus_pulldown,
    .ext_vbus_gen);

  ultc_far_end u_ultc_far_end (.host_power, .suspend_req, .vbus_gen_on,
    .ext_vbus_gen, .vbus_session_valid, .bus_suspended);

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    compares = compares + 1;
    if (seen !== want)
    begin
      fails = fails + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // readies only move after an edge, so the negedge value is the edge value
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    logic ra, rw, rb;
    logic [1:0] rp;
    rb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!rb)
    begin
      @(negedge clock);
      ra = s_axi_awready & s_axi_awvalid;
      rw = s_axi_wready & s_axi_wvalid;
      rb = s_axi_bvalid;
      rp = s_axi_bresp;
      @(posedge clock);
      if (ra)
        s_axi_awvalid <= 1'h0;
      if (rw)
        s_axi_wvalid <= 1'h0;
    end
    check(rp, resp);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    logic ra, rv;
    logic [33:0] got;
    rv = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!rv)
    begin
      @(negedge clock);
      ra = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge clock);
      if (ra)
        s_axi_arvalid <= 1'h0;
    end
    check(got, {resp, d});
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    fails = fails + 1;
    final_report();
  end

  initial
  begin
    rows = '{'{8'h01, 8'h00, 8'h01, 1'h1, 1'h0, 8'h80},
      '{8'h01, 8'h00, 8'h01, 1'h0, 1'h0, 8'h00},
      '{8'h01, 8'h00, 8'h01, 1'h1, 1'h1, 8'h80},
      '{8'h09, 8'h00, 8'h03, 1'h1, 1'h0, 8'h70},
      '{8'h08, 8'h00, 8'h03, 1'h0, 1'h0, 8'h70},
      '{8'h00, 8'h84, 8'h00, 1'h1, 1'h0, 8'h80},
      '{8'h01, 8'h04, 8'h01, 1'h1, 1'h0, 8'h00},
      '{8'h00, 8'h84, 8'h00, 1'h0, 1'h0, 8'h00},
      '{8'h08, 8'h24, 8'h02, 1'h1, 1'h0, 8'h50},
      '{8'h00, 8'h14, 8'h00, 1'h1, 1'h0, 8'h20},
      '{8'h01, 8'h00, 8'h05, 1'h1, 1'h0, 8'h08},
      '{8'h08, 8'h00, 8'h06, 1'h0, 1'h0, 8'h07},
      '{8'h00, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00}};
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    axi_read(ULTC_OFF_USB_CTL, 32'h0, ULTC_RESP_OKAY);
    foreach (rows[i])
    begin
      // registers touched only while the host powers the bus
      host_power <= 1'h1;
      suspend_req <= 1'h0;
      repeat (4) @(posedge clock);
      axi_write(ULTC_OFF_PWR_CTL, {24'h0, rows[i].pwr}, ULTC_RESP_OKAY);
      axi_write(ULTC_OFF_OTG_CTL, {24'h0, rows[i].otg}, ULTC_RESP_OKAY);
      axi_write(ULTC_OFF_USB_CTL, {24'h0, rows[i].usb}, ULTC_RESP_OKAY);
      host_power <= rows[i].sess;
      suspend_req <= rows[i].susp;
      repeat (6) @(posedge clock);
      check(outs, rows[i].exp);
    end
    // suspended device keeps its pull-up, seen in status too
    axi_write(ULTC_OFF_USB_CTL, 32'h1, ULTC_RESP_OKAY);
    axi_write(ULTC_OFF_PWR_CTL, 32'h1, ULTC_RESP_OKAY);
    suspend_req <= 1'h1;
    repeat (6) @(posedge clock);
    axi_read(ULTC_OFF_STATUS, 32'h13, ULTC_RESP_OKAY);
    axi_write(ULTC_OFF_STATUS, 32'hFF, ULTC_RESP_OKAY);
    axi_read(ULTC_OFF_STATUS, 32'h13, ULTC_RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    axi_write(ULTC_OFF_USB_CTL, 32'h0, ULTC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    repeat (4) @(posedge clock);
    check(outs, 8'h80);
    axi_write(8'h10, 32'h0, ULTC_RESP_SLVERR);
    axi_read(8'h10, 32'h0, ULTC_RESP_SLVERR);
    axi_write(ULTC_OFF_OTG_CTL, 32'hFF, ULTC_RESP_OKAY);
    axi_read(ULTC_OFF_OTG_CTL, 32'hB4, ULTC_RESP_OKAY);
    // override sets pull-up and both pull-downs at once
    axi_read(ULTC_OFF_STATUS, 32'h1F, ULTC_RESP_OKAY);
    check(outs, 8'hE0);
    // reset in mid-run drops every resistor and clears the registers
    rstn <= 1'h0;
    repeat (2) @(posedge clock);
    check(outs, 8'h00);
    rstn <= 1'h1;
    @(posedge clock);
    axi_read(ULTC_OFF_OTG_CTL, 32'h0, ULTC_RESP_OKAY);
    final_report();
  end
endmodule
`default_nettype wire
